// ### mcat_pkg.sv
// Purpose: shared constants and types of the motor constant autotune block
// Assumes: 100 MHz clock, AXI4-Lite register access with 32-bit data
// Notes:   times are kept in their own unit and turned into counts here
package mcat_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] MCAT_OFS_CTRL   = 8'h00;
  localparam logic [7:0] MCAT_OFS_CMD    = 8'h04;
  localparam logic [7:0] MCAT_OFS_STATUS = 8'h08;
  localparam logic [7:0] MCAT_OFS_CONST0 = 8'h10;
  localparam int         MCAT_NUM_CONST  = 5;

  // ctrl field positions
  localparam int MCAT_CTRL_TMODE_LSB = 0;
  localparam int MCAT_CTRL_DSEL_LSB  = 2;
  localparam int MCAT_CTRL_BRAKE_BIT = 4;
  localparam int MCAT_CTRL_FREEVF_BIT = 5;
  // command bits, write one to act
  localparam int MCAT_CMD_RUN_BIT  = 0;
  localparam int MCAT_CMD_STOP_BIT = 1;
  localparam int MCAT_CMD_KEY_BIT  = 2;

  // tuning_mode_select codes
  localparam logic [1:0] MCAT_TMODE_OFF    = 2'h0;
  localparam logic [1:0] MCAT_TMODE_STILL  = 2'h1;
  localparam logic [1:0] MCAT_TMODE_ROTATE = 2'h2;
  // constant_set_select codes
  localparam logic [1:0] MCAT_DSEL_STD      = 2'h0;
  localparam logic [1:0] MCAT_DSEL_TUNED    = 2'h1;
  localparam logic [1:0] MCAT_DSEL_ADAPTIVE = 2'h2;
  // dc_brake_enable_setting codes
  localparam logic MCAT_BRAKE_OFF = 1'h0;
  localparam logic MCAT_BRAKE_ON  = 1'h1;

  // result codes shown in status
  localparam logic [1:0] MCAT_RES_NONE     = 2'h0;
  localparam logic [1:0] MCAT_RES_NORMAL   = 2'h1;
  localparam logic [1:0] MCAT_RES_ABNORMAL = 2'h2;
  localparam logic [1:0] MCAT_RES_FAIL     = 2'h3;

  localparam logic [1:0] MCAT_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MCAT_RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int MCAT_CLK_HZ      = 100_000_000;
  localparam int MCAT_TICK_US     = 1000;
  localparam int MCAT_TICK_CYCLES = MCAT_CLK_HZ / 1_000_000 * MCAT_TICK_US;
  localparam int MCAT_SLV_T1_S    = 50;
  localparam int MCAT_SLV_T2_S    = 100;
  localparam int MCAT_ADAPT_S     = 5;
  localparam int MCAT_TICKS_PER_S = 1_000_000 / MCAT_TICK_US;
  localparam logic [16:0] MCAT_SLV_T1_TICKS =
    17'(MCAT_SLV_T1_S * MCAT_TICKS_PER_S);
  localparam logic [16:0] MCAT_SLV_T2_TICKS =
    17'(MCAT_SLV_T2_S * MCAT_TICKS_PER_S);
  localparam logic [16:0] MCAT_ADAPT_TICKS  =
    17'(MCAT_ADAPT_S * MCAT_TICKS_PER_S);

  // speed targets in percent of base frequency
  localparam logic [6:0] MCAT_PCT_VF   = 7'h50;
  localparam logic [6:0] MCAT_PCT_SLV1 = 7'h28;
  localparam logic [6:0] MCAT_PCT_SLV2 = 7'h14;
  localparam logic [6:0] MCAT_PCT_SLV3 = 7'h0A;
  localparam logic [6:0] MCAT_PCT_NONE = 7'h00;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    MCAT_IDLE, MCAT_RUN, MCAT_AC1, MCAT_AC2, MCAT_DC1, MCAT_VF,
    MCAT_SLV, MCAT_DC2, MCAT_BRAKE_WAIT, MCAT_ADAPT
  } mcat_state_t;

  // what the power stage is asked to do
  typedef struct packed {
    logic        run;
    mcat_state_t step;
    logic [6:0]  speed_pct;
  } mcat_drive_cmd_t;

  // what the power stage reports back (pin side)
  typedef struct packed {
    logic        step_done;
    logic        step_ok;
    logic        motor_stopped;
    logic        dc_braking;
  } mcat_drive_sts_t;

endpackage

// ### mcat_const_mem.sv
// Purpose: two banks of motor constants, one live and one being measured
// Assumes: single clock, one write and one read port
// Notes:   read data come out of a register, one cycle after the address
`timescale 1ns/1ns
`default_nettype none
module mcat_const_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 10,
  parameter int AW    = 4
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output var  logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array: contents are undefined until first tuning
  always_ff @(posedge clk_i) begin
    if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= '0;
    end else if (int'(rd_addr_i) < DEPTH) begin
      rd_data_o <= mem[rd_addr_i];
    end else begin
      rd_data_o <= '0;
    end
  end

endmodule
`default_nettype wire

// ### mcat_autotune.sv
// Purpose: motor constant measurement and adaptive refinement sequencer
// Assumes: power stage pins are asynchronous; operator works over AXI4-Lite
// Notes:   measured words are kept in a spare bank until the run passes; the adaptive word goes straight to the live bank
`timescale 1ns/1ns
`default_nettype none
module mcat_autotune
  import mcat_pkg::*;
#(
  parameter int TICK_CYCLES = MCAT_TICK_CYCLES,
  parameter int AW          = 8
) (
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  input  wire logic [AW-1:0]           s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output var  logic                    s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output var  logic                    s_axi_wready,
  output var  logic [1:0]              s_axi_bresp,
  output var  logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [AW-1:0]           s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output var  logic                    s_axi_arready,
  output var  logic [31:0]             s_axi_rdata,
  output var  logic [1:0]              s_axi_rresp,
  output var  logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire mcat_pkg::mcat_drive_sts_t drive_sts_i,
  input  wire logic [31:0]             meas_value_i,
  output var  mcat_pkg::mcat_drive_cmd_t drive_cmd_o
);
  import mcat_pkg::*;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  mcat_drive_sts_t sts_meta, sts_s;
  logic            done_d;
  // the measured word is a pin bus too; it changes with done and passes the same two stages
  logic [31:0]     meas_meta, meas_s;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sts_meta <= '0;
      sts_s    <= '0;
      meas_meta <= 32'h0;
      meas_s   <= 32'h0;
      done_d   <= 1'b0;
    end else begin
      sts_meta <= drive_sts_i;
      sts_s    <= sts_meta;
      meas_meta <= meas_value_i;
      meas_s   <= meas_meta;
      done_d   <= sts_s.step_done;
    end
  end
  wire logic done_rise = sts_s.step_done && !done_d;

  // ------------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------------
  logic [1:0]  tmode, dsel, next_tmode, next_dsel;
  logic        brake_en, free_vf, next_brake_en, next_free_vf;
  logic        aw_have, w_have, next_aw_have, next_w_have;
  logic [AW-1:0] aw_addr, next_aw_addr, ar_addr, next_ar_addr;
  logic [31:0] w_data, next_w_data;
  logic        w_lane0, next_w_lane0;
  logic        rd_wait, next_rd_wait;
  logic        next_awready, next_wready, next_bvalid, next_arready;
  logic        next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, status_word, mem_rdata;
  logic        run_req, stop_req, key_req;

  function automatic logic is_const(input logic [AW-1:0] a);
    return (a >= AW'(MCAT_OFS_CONST0)) &&
           (a <  AW'(MCAT_OFS_CONST0 + 8'(4 * MCAT_NUM_CONST))) &&
           (a[1:0] == 2'h0);
  endfunction

  always_comb begin
    next_tmode = tmode;
    next_dsel = dsel;
    next_brake_en = brake_en;
    next_free_vf = free_vf;
    next_aw_have = aw_have;
    next_w_have = w_have;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_ar_addr = ar_addr;
    next_rd_wait = rd_wait;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    run_req = 1'b0;
    stop_req = 1'b0;
    key_req = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_have = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // both halves held: perform the write and answer
    if (aw_have && w_have && !s_axi_bvalid) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = MCAT_RESP_OKAY;
      if (aw_addr == AW'(MCAT_OFS_CTRL)) begin
        if (w_lane0) begin
          next_tmode = w_data[MCAT_CTRL_TMODE_LSB +: 2];
          next_dsel = w_data[MCAT_CTRL_DSEL_LSB +: 2];
          next_brake_en = w_data[MCAT_CTRL_BRAKE_BIT];
          next_free_vf = w_data[MCAT_CTRL_FREEVF_BIT];
        end
      end else if (aw_addr == AW'(MCAT_OFS_CMD)) begin
        run_req = w_lane0 && w_data[MCAT_CMD_RUN_BIT];
        stop_req = w_lane0 && w_data[MCAT_CMD_STOP_BIT];
        key_req = w_lane0 && w_data[MCAT_CMD_KEY_BIT];
      end else if (!(aw_addr == AW'(MCAT_OFS_STATUS) ||
                     is_const(aw_addr))) begin
        next_bresp = MCAT_RESP_SLVERR;
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_ar_addr = s_axi_araddr;
      next_rd_wait = 1'b1;
    end
    // one wait cycle lets the constant memory present its word
    if (rd_wait && !s_axi_arready) begin
      next_rd_wait = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = MCAT_RESP_OKAY;
      if (ar_addr == AW'(MCAT_OFS_CTRL)) begin
        next_rdata = 32'({free_vf, brake_en, dsel, tmode});
      end else if (ar_addr == AW'(MCAT_OFS_STATUS)) begin
        next_rdata = status_word;
      end else if (is_const(ar_addr)) begin
        next_rdata = mem_rdata;
      end else begin
        next_rdata = 32'h0;
        next_rresp = (ar_addr == AW'(MCAT_OFS_CMD)) ? MCAT_RESP_OKAY
                                                    : MCAT_RESP_SLVERR;
      end
    end
    next_awready = !next_aw_have && !next_bvalid;
    next_wready = !next_w_have && !next_bvalid;
    next_arready = !next_rd_wait && !next_rvalid;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tmode <= MCAT_TMODE_OFF;
      dsel <= MCAT_DSEL_STD;
      brake_en <= MCAT_BRAKE_OFF;
      free_vf <= 1'b0;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_lane0 <= 1'b0;
      ar_addr <= '0;
      rd_wait <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MCAT_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= MCAT_RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end else begin
      tmode <= next_tmode;
      dsel <= next_dsel;
      brake_en <= next_brake_en;
      free_vf <= next_free_vf;
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      ar_addr <= next_ar_addr;
      rd_wait <= next_rd_wait;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  mcat_state_t state, next_state;
  logic [16:0] tick_cnt, next_tick_cnt, step_ticks, next_step_ticks;
  logic        all_ok, next_all_ok, bank, next_bank;
  logic [1:0]  result, next_result;
  logic        mem_we;
  logic [2:0]  mem_idx, rd_idx;
  logic        mem_bank;
  logic        tick;

  // memory word index of the constant each step measures
  function automatic logic [2:0] step_slot(input mcat_state_t s);
    unique case (s)
      MCAT_AC1: return 3'h0;
      MCAT_AC2: return 3'h1;
      MCAT_DC1: return 3'h2;
      MCAT_DC2: return 3'h3;
      default:  return 3'h4;
    endcase
  endfunction

  function automatic logic [3:0] mem_addr(input logic b, input logic [2:0] i);
    return b ? 4'(i) + 4'(MCAT_NUM_CONST) : 4'(i);
  endfunction

  assign tick = (tick_cnt == 17'(TICK_CYCLES - 1));

  always_comb begin
    next_state = state;
    next_all_ok = all_ok;
    next_bank = bank;
    next_result = result;
    next_tick_cnt = tick ? 17'h0 : tick_cnt + 17'h1;
    next_step_ticks = (tick && step_ticks != 17'h1FFFF) ? step_ticks + 17'h1
                                                        : step_ticks;
    mem_we = 1'b0;
    mem_bank = !bank;
    mem_idx = step_slot(state);
    // key clears first so a result set this cycle survives
    if (key_req) begin
      next_result = MCAT_RES_NONE;
    end
    unique case (state)
      MCAT_IDLE: begin
        if (run_req && tmode != MCAT_TMODE_OFF) begin
          if (free_vf) begin
            next_result = MCAT_RES_ABNORMAL;
          end else if (sts_s.motor_stopped) begin
            next_state = MCAT_AC1;
            next_all_ok = 1'b1;
          end
        end else if (run_req) begin
          next_state = MCAT_RUN;
        end
      end
      MCAT_RUN: begin
        if (stop_req) begin
          next_state = (dsel == MCAT_DSEL_ADAPTIVE && tmode == MCAT_TMODE_OFF)
                       ? MCAT_BRAKE_WAIT : MCAT_IDLE;
        end
      end
      MCAT_BRAKE_WAIT: begin
        if (run_req) begin
          next_state = MCAT_RUN;
        end else if (sts_s.motor_stopped &&
                     !(brake_en && sts_s.dc_braking)) begin
          next_state = MCAT_ADAPT;
          next_step_ticks = 17'h0;
        end
      end
      MCAT_ADAPT: begin
        if (run_req) begin
          next_state = MCAT_RUN;
        end else if (step_ticks >= MCAT_ADAPT_TICKS) begin
          next_state = MCAT_IDLE;
          mem_we = sts_s.step_ok;
          mem_bank = bank;
        end
      end
      default: begin
        // measurement steps: a run or stop command aborts the run, a key command does not
        if (run_req || stop_req) begin
          next_state = MCAT_IDLE;
          next_result = MCAT_RES_ABNORMAL;
        end else if (done_rise) begin
          next_step_ticks = 17'h0;
          next_all_ok = all_ok && sts_s.step_ok;
          mem_we = (state != MCAT_VF);
          unique case (state)
            MCAT_AC1: next_state = MCAT_AC2;
            MCAT_AC2: next_state = MCAT_DC1;
            MCAT_DC1: next_state = (tmode == MCAT_TMODE_ROTATE)
                                   ? MCAT_VF : MCAT_DC2;
            MCAT_VF:  next_state = MCAT_SLV;
            default: begin
              if (state == MCAT_SLV) begin
                next_state = MCAT_DC2;
              end else begin
                next_state = MCAT_IDLE;
                if (all_ok && sts_s.step_ok) begin
                  next_bank = !bank;
                  next_result = MCAT_RES_NORMAL;
                end else begin
                  next_result = MCAT_RES_FAIL;
                end
              end
            end
          endcase
        end
      end
    endcase
  end

  function automatic logic [6:0] speed_of(input mcat_state_t s,
                                          input logic [16:0] t);
    if (s == MCAT_VF) begin
      return MCAT_PCT_VF;
    end else if (s != MCAT_SLV) begin
      return MCAT_PCT_NONE;
    end else if (t < MCAT_SLV_T1_TICKS) begin
      return MCAT_PCT_SLV1;
    end else if (t < MCAT_SLV_T2_TICKS) begin
      return MCAT_PCT_SLV2;
    end
    return MCAT_PCT_SLV3;
  endfunction

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= MCAT_IDLE;
      tick_cnt <= 17'h0;
      step_ticks <= 17'h0;
      all_ok <= 1'b0;
      bank <= 1'b0;
      result <= MCAT_RES_NONE;
      drive_cmd_o <= '{run: 1'b0, step: MCAT_IDLE, speed_pct: MCAT_PCT_NONE};
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      step_ticks <= next_step_ticks;
      all_ok <= next_all_ok;
      bank <= next_bank;
      result <= next_result;
      drive_cmd_o <= '{run: (next_state == MCAT_RUN), step: next_state,
                       speed_pct: speed_of(next_state, next_step_ticks)};
    end
  end

  assign status_word = 32'({bank, result, state});
  // address the memory at the AR edge so its word is ready one cycle later
  assign rd_idx = 3'((next_ar_addr - AW'(MCAT_OFS_CONST0)) >> 2);

  mcat_const_mem #(
    .WIDTH (32),
    .DEPTH (2 * MCAT_NUM_CONST),
    .AW    (4)
  ) u_mem (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .wr_en_i   (mem_we),
    .wr_addr_i (mem_addr(mem_bank, mem_idx)),
    .wr_data_i (meas_s),
    .rd_addr_i (mem_addr(bank, rd_idx)),
    .rd_data_o (mem_rdata)
  );

endmodule
`default_nettype wire

// ### mcat_autotune_sva.sv
// Purpose: port checks of the autotune sequencer
// Assumes: one clock, reset active high
// Notes:   step order and speed targets of the tuning sequence
`timescale 1ns/1ns
`default_nettype none
module mcat_autotune_sva
  import mcat_pkg::*;
(
  input wire logic                      clk_i,
  input wire logic                      reset_i,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic [1:0]                s_axi_bresp,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire mcat_pkg::mcat_drive_cmd_t drive_cmd_o
);
  import mcat_pkg::*;
  mcat_state_t st;
  logic [6:0]  pct;
  assign st = drive_cmd_o.step;
  assign pct = drive_cmd_o.speed_pct;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  b_delay_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  r_delay_a: assert property (s_axi_arvalid && s_axi_arready |->
    ##[1:2] s_axi_rvalid) else $error("no read data");
  r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  // ----------------------------------------------------------------
  // step order and speeds
  // ----------------------------------------------------------------
  ac1_next_a: assert property (
    $changed(st) && $past(st) == MCAT_AC1 |-> st inside {MCAT_AC2, MCAT_IDLE})
    else $error("bad step after first ac");
  ac2_next_a: assert property (
    $changed(st) && $past(st) == MCAT_AC2 |-> st inside {MCAT_DC1, MCAT_IDLE})
    else $error("bad step after second ac");
  dc1_next_a: assert property (
    $changed(st) && $past(st) == MCAT_DC1 |->
    st inside {MCAT_VF, MCAT_DC2, MCAT_IDLE}) else $error("bad step after dc");
  vf_speed_a: assert property (st == MCAT_VF |-> pct == MCAT_PCT_VF)
    else $error("bad vf speed");
  slv_speed_a: assert property (
    $changed(st) && st == MCAT_SLV |-> pct == MCAT_PCT_SLV1)
    else $error("bad vector run speed");
endmodule
`default_nettype wire

// ### mcat_power_stage.sv
// Purpose: behavioural power stage facing the sequencer
// Assumes: bench sets pass, spin, braking and hold
// Notes:   measured word only valid while a step is reported done
`timescale 1ns/1ns
`default_nettype none
module mcat_power_stage
  import mcat_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire mcat_pkg::mcat_drive_cmd_t drive_cmd_i,
  input  wire logic                      ok_i,
  input  wire logic                      spin_i,
  input  wire logic                      brk_i,
  input  wire logic                      hold_i,
  input  wire logic [31:0]               base_i,
  output var  mcat_pkg::mcat_drive_sts_t drive_sts_o,
  output var  logic [31:0]               meas_o
);
  import mcat_pkg::*;
  mcat_state_t last = MCAT_IDLE;
  logic [3:0]  cnt = 4'h0;
  logic [31:0] word;
  always_ff @(posedge clk_i) begin
    last <= drive_cmd_i.step;
    cnt <= (drive_cmd_i.step != last) ? 4'h0 : cnt + 4'(cnt != 4'hF);
  end
  // done stands until the step code moves on, hold_i stalls a step
  assign drive_sts_o.step_done = drive_cmd_i.step inside
    {[MCAT_AC1:MCAT_DC2]} && drive_cmd_i.step == last && cnt > 4'h4 && !hold_i;
  assign drive_sts_o.step_ok = ok_i;
  assign drive_sts_o.motor_stopped = !drive_cmd_i.run && !spin_i;
  assign drive_sts_o.dc_braking = brk_i;
  assign word = base_i + 32'(drive_cmd_i.step);
  // outside a done step the word is not held, so show its inverse
  assign meas_o = drive_sts_o.step_done ? word : ~word;
endmodule
`default_nettype wire

// ### test_mcat_autotune.sv
// Purpose: self-checking bench of the autotune sequencer
// Assumes: short tick so step timers stay small
// Notes:   sequence rows first, then refusal, abort and adaptive cases
`timescale 1ns/1ns
`default_nettype none
module test_mcat_autotune;
  import mcat_pkg::*;
  typedef struct {
    logic [7:0] ctrl; logic ok; logic [31:0] base, c0;
    logic [1:0] res; logic [7:0] mask;
  } mcat_row_t;
  logic clk_i, reset_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, ok, spin, brk, hold;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, base, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] seen;
  int          error_cnt = 0;
  int          checks = 0;
  mcat_drive_cmd_t cmd;
  mcat_drive_sts_t sts;
  logic [31:0] meas;
  mcat_row_t rows[4] = '{
    '{8'h01, 1'b1, 32'h1000, 32'h1002, MCAT_RES_NORMAL, 8'h9D},
    '{8'h06, 1'b1, 32'h2000, 32'h2002, MCAT_RES_NORMAL, 8'hFD},
    '{8'h01, 1'b0, 32'h3000, 32'h2002, MCAT_RES_FAIL, 8'h00},
    '{8'h21, 1'b1, 32'h4000, 32'h2002, MCAT_RES_ABNORMAL, 8'h01}};
  mcat_autotune #(.TICK_CYCLES(10)) dut (.clk_i, .reset_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .drive_sts_i(sts), .meas_value_i(meas), .drive_cmd_o(cmd));
  mcat_power_stage stage (.clk_i, .drive_cmd_i(cmd), .ok_i(ok), .spin_i(spin),
    .brk_i(brk), .hold_i(hold), .base_i(base), .drive_sts_o(sts),
    .meas_o(meas));
  always @(negedge clk_i) seen[cmd.step] = 1'b1;
  task automatic complete_run;
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic limit(inout int n);
    if (++n > 3000) begin
      error_cnt++;
      complete_run;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic ta, tw, tb, tv;
    n = 0;
    tb = 0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!tb) begin
      @(negedge clk_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tv = s_axi_bvalid;
      tb = tv && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tv && !tb) s_axi_bready <= 1'b1;
      limit(n);
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic ta, tr, tv;
    n = 0;
    tr = 0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!tr) begin
      @(negedge clk_i);
      ta = s_axi_arvalid && s_axi_arready;
      tv = s_axi_rvalid;
      tr = tv && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_i);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tv && !tr) s_axi_rready <= 1'b1;
      limit(n);
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic wt(input mcat_state_t s);
    int n;
    n = 0;
    while (cmd.step !== s) begin
      @(negedge clk_i);
      limit(n);
    end
  endtask
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {reset_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'hF - 4'h7;
    {s_axi_arvalid, s_axi_rready, ok, spin, brk, hold} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, base} = '0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(MCAT_OFS_STATUS);
    chk("status", 32'h0, d);
    chk("drive", 32'h0, 32'(cmd));
    foreach (rows[i]) begin
      ok <= rows[i].ok;
      base <= rows[i].base;
      wr(MCAT_OFS_CTRL, 32'(rows[i].ctrl));
      chk("bresp", 32'(MCAT_RESP_OKAY), 32'(r));
      seen = '0;
      wr(MCAT_OFS_CMD, 32'h1);
      wt(MCAT_IDLE);
      rd(MCAT_OFS_STATUS);
      chk("result", 32'(rows[i].res), 32'(d[5:4]));
      rd(MCAT_OFS_CONST0);
      chk("const0", rows[i].c0, d);
      if (rows[i].mask != 8'h00)
        chk("steps", 32'(rows[i].mask), 32'(seen));
      wr(MCAT_OFS_CMD, 32'h4);
      rd(MCAT_OFS_STATUS);
      chk("cleared", 32'h0, 32'(d[5:4]));
    end
    spin <= 1'b1;
    wr(MCAT_OFS_CTRL, 32'h01);
    wr(MCAT_OFS_CMD, 32'h1);
    repeat (3) @(negedge clk_i);
    chk("refused", 32'(MCAT_IDLE), 32'(cmd.step));
    spin <= 1'b0;
    hold <= 1'b1;
    wr(MCAT_OFS_CMD, 32'h1);
    wr(MCAT_OFS_CMD, 32'h2);
    wt(MCAT_IDLE);
    hold <= 1'b0;
    rd(MCAT_OFS_STATUS);
    chk("abort", 32'(MCAT_RES_ABNORMAL), 32'(d[5:4]));
    rd(MCAT_OFS_CONST0);
    chk("kept", 32'h2002, d);
    wr(MCAT_OFS_CTRL, 32'h18);
    wr(MCAT_OFS_CMD, 32'h1);
    wt(MCAT_RUN);
    brk <= 1'b1;
    wr(MCAT_OFS_CMD, 32'h2);
    wt(MCAT_BRAKE_WAIT);
    repeat (20) @(negedge clk_i);
    chk("brake", 32'(MCAT_BRAKE_WAIT), 32'(cmd.step));
    brk <= 1'b0;
    wt(MCAT_ADAPT);
    wr(MCAT_OFS_CMD, 32'h1);
    wt(MCAT_RUN);
    rd(MCAT_OFS_CONST0 + 8'h10);
    chk("const4", 32'h2006, d);
    wr(8'h40, 32'h0);
    chk("wresp", 32'(MCAT_RESP_SLVERR), 32'(r));
    rd(8'h40);
    chk("unmapped", 32'(MCAT_RESP_SLVERR), 32'(r));
    complete_run;
  end
endmodule
bind mcat_autotune mcat_autotune_sva sva (.clk_i, .reset_i, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .drive_cmd_o);
`default_nettype wire
